// *** hdl/port_consts.svh ***
/*
 * Offsets, field positions, reset values and fixed pin roles of the
 * four-bit I/O port. Assumes a 32-bit register word with the four pin
 * bits at positions 6 down to 3.
 */
`ifndef PORT_CONSTS_SVH
`define PORT_CONSTS_SVH

// Register byte offsets from the port base
`define OFS_DATA      8'h00
`define OFS_OE        8'h04
`define OFS_FSEL1     8'h08
`define OFS_FSEL2     8'h0c
`define OFS_FSEL3     8'h10
`define OFS_FSEL4     8'h14
`define OFS_FSEL5     8'h18
`define OFS_OD        8'h28
`define OFS_PU        8'h2c
`define OFS_PD        8'h30
`define OFS_IE        8'h38

// Pin field inside each register word
`define FLD_LO        3
`define FLD_HI        6

// Reset words
`define RST_DATA      32'h0000_0000
`define RST_OE        32'h0000_0028
`define RST_FSEL1     32'h0000_0078
`define RST_FSELX     32'h0000_0000
`define RST_OD        32'h0000_0000
`define RST_PU        32'h0000_0048
`define RST_PD        32'h0000_0010
`define RST_IE        32'h0000_0058

// Function register index (0-based) and pin roles
`define FN_DEBUG      0
`define FN_INT        3
`define PIN_INT       3
`define DBG_IN_MASK   4'hb
`define DBG_OUT_MASK  4'h5
`define DBG_PU_MASK   4'h9
`define DBG_PD_MASK   4'h2

// Bus encodings
`define HTRANS_IDLE   2'h0

`endif

// *** hdl/port_pkg.sv ***
/*
 * Types shared by the four-bit I/O port modules.
 * Assumes port_consts.svh supplies the numbers.
 */
package port_pkg;

    localparam int PINS  = 4;
    localparam int FUNCS = 5;

    typedef logic [PINS-1:0]            pins_t;
    typedef logic [FUNCS-1:0][PINS-1:0] fn_t;

    // Software-visible control state
    typedef struct packed {
        pins_t data;
        pins_t oe;
        fn_t   fsel;
        pins_t od;
        pins_t pu;
        pins_t pd;
        pins_t ie;
    } regs_s;

    // Pad controls for the four pins
    typedef struct packed {
        pins_t out;
        pins_t oe;
        pins_t ie;
        pins_t pu;
        pins_t pd;
    } pad_s;

    // Captured bus address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } aph_s;

endpackage

// *** hdl/pin_sync.sv ***
/*
 * Two-stage synchroniser for the pad inputs.
 * Assumes inputs are asynchronous to mclk; only the second stage is read.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 4
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_s;

    sync_s s_r;
    sync_s s_nxt;

    // Meta stage feeds only the stable stage
    always_comb begin
        s_nxt        = s_r;
        s_nxt.meta   = d;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.stable;

endmodule

`default_nettype wire

// *** hdl/pin_ctrl.sv ***
/*
 * Per-pin steering: picks port or alternate function, applies STOP-mode
 * gating, open-drain and pulls. Purely combinational.
 * Assumes the caller registers every result before it reaches a pad.
 */
`timescale 1ns/1ps
`default_nettype none
`include "port_consts.svh"

module pin_ctrl
    import port_pkg::*;
(
    input  wire regs_s regs,
    input  wire logic  stopMode,
    input  wire logic  standbyDrive,
    input  wire fn_t   altOut,
    input  wire fn_t   altValid,
    input  wire pins_t pinIn,
    output var  pad_s  pad,
    output var  pins_t altIn,
    output logic       extInt
);

    // Fixed debug roles as typed constants; a bare literal cannot be bit-selected
    localparam pins_t DbgIn  = `DBG_IN_MASK;
    localparam pins_t DbgOut = `DBG_OUT_MASK;
    localparam pins_t DbgPu  = `DBG_PU_MASK;
    localparam pins_t DbgPd  = `DBG_PD_MASK;

    logic gate;
    assign gate = !stopMode || standbyDrive;

    // Each pin chooses its source independently
    always_comb begin
        logic sel;
        logic dbg;
        logic outV;
        logic oeV;
        pad   = '0;
        altIn = '0;
        sel   = 1'b0;
        dbg   = 1'b0;
        outV  = 1'b0;
        oeV   = 1'b0;
        for (int p = 0; p < PINS; p++) begin
            sel  = 1'b0;
            outV = 1'b0;
            oeV  = 1'b0;
            for (int f = 0; f < FUNCS; f++) begin
                sel  = sel | regs.fsel[f][p];
                outV = outV | (regs.fsel[f][p] & altOut[f][p]);
                oeV  = oeV | (regs.fsel[f][p] & altValid[f][p]);
            end
            dbg = regs.fsel[`FN_DEBUG][p];
            if (dbg) begin
                // Debug pins keep fixed roles; outputs float while data invalid
                pad.ie[p]  = DbgIn[p];
                pad.oe[p]  = DbgOut[p] & altValid[`FN_DEBUG][p];
                pad.out[p] = altOut[`FN_DEBUG][p];
                pad.pu[p]  = DbgPu[p] | regs.pu[p];
                pad.pd[p]  = DbgPd[p] | regs.pd[p];
            end else begin
                pad.out[p] = sel ? outV : regs.data[p];
                pad.oe[p]  = (sel ? oeV : regs.oe[p]) & gate;
                // Interrupt pin stays awake in STOP without standby drive only when selected
                pad.ie[p]  = regs.ie[p] & (gate | (p == `PIN_INT && regs.fsel[`FN_INT][p]));
                pad.pu[p]  = regs.pu[p];
                pad.pd[p]  = regs.pd[p];
            end
            // Open drain: never drive the high level
            if (regs.od[p] && pad.out[p]) begin
                pad.oe[p] = 1'b0;
            end
            altIn[p] = pinIn[p] & pad.ie[p];
        end
    end

    // Outside STOP the interrupt follows the input enable alone
    assign extInt = pinIn[`PIN_INT] & regs.ie[`PIN_INT]
                  & (!stopMode | regs.fsel[`FN_INT][`PIN_INT]);

endmodule

`default_nettype wire

// *** hdl/four_bit_io_port.sv ***
/*
 * Four-bit general-purpose I/O port with alternate pin functions,
 * reached over an AHB-Lite slave with zero wait states.
 * Assumes hsel decodes the port base, STOP mode and standby drive come
 * from mclk-domain logic, and pads resolve pulls and enables outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "port_consts.svh"

module four_bit_io_port
    import port_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        stopMode,
    input  wire logic        standbyDrive,
    input  wire fn_t         altOut,
    input  wire fn_t         altValid,
    output pins_t            altIn,
    output logic             extIntA,
    input  wire pins_t       padIn,
    output pad_s             pad
);

    typedef struct packed {
        regs_s       regs;
        aph_s        aph;
        pad_s        pad;
        logic [31:0] rdata;
        logic        ready;
        logic        resp;
        pins_t       altIn;
        logic        extInt;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    pins_t  pinSync;
    pad_s   padNxt;
    pins_t  altInNxt;
    logic   extIntNxt;

    // Reset words as full-width constants so the pin field can be sliced
    localparam logic [31:0] RstData  = `RST_DATA;
    localparam logic [31:0] RstOe    = `RST_OE;
    localparam logic [31:0] RstFsel1 = `RST_FSEL1;
    localparam logic [31:0] RstFselX = `RST_FSELX;
    localparam logic [31:0] RstOd    = `RST_OD;
    localparam logic [31:0] RstPu    = `RST_PU;
    localparam logic [31:0] RstPd    = `RST_PD;
    localparam logic [31:0] RstIe    = `RST_IE;

    // Reset image of the control registers
    function automatic regs_s regsReset();
        regs_s r;
        r      = '0;
        r.data = RstData[`FLD_HI:`FLD_LO];
        r.oe   = RstOe[`FLD_HI:`FLD_LO];
        for (int f = 1; f < FUNCS; f++) begin
            r.fsel[f] = RstFselX[`FLD_HI:`FLD_LO];
        end
        r.fsel[`FN_DEBUG] = RstFsel1[`FLD_HI:`FLD_LO];
        r.od   = RstOd[`FLD_HI:`FLD_LO];
        r.pu   = RstPu[`FLD_HI:`FLD_LO];
        r.pd   = RstPd[`FLD_HI:`FLD_LO];
        r.ie   = RstIe[`FLD_HI:`FLD_LO];
        return r;
    endfunction

    // Decode of an offset to the register field; used for reads and writes
    function automatic logic [3:0] regIndex(input logic [7:0] a);
        case (a)
            `OFS_DATA:  regIndex = 4'h1;
            `OFS_OE:    regIndex = 4'h2;
            `OFS_FSEL1: regIndex = 4'h3;
            `OFS_FSEL2: regIndex = 4'h4;
            `OFS_FSEL3: regIndex = 4'h5;
            `OFS_FSEL4: regIndex = 4'h6;
            `OFS_FSEL5: regIndex = 4'h7;
            `OFS_OD:    regIndex = 4'h8;
            `OFS_PU:    regIndex = 4'h9;
            `OFS_PD:    regIndex = 4'ha;
            `OFS_IE:    regIndex = 4'hb;
            default:    regIndex = 4'h0;
        endcase
    endfunction

    // Read word; pins with input enabled show the pad, others the latch
    function automatic logic [31:0] readWord(input regs_s r, input logic [7:0] a, input pins_t pin);
        pins_t f;
        logic [31:0] w;
        case (regIndex(a))
            4'h1:    f = (pin & r.ie) | (r.data & ~r.ie);
            4'h2:    f = r.oe;
            4'h3:    f = r.fsel[0];
            4'h4:    f = r.fsel[1];
            4'h5:    f = r.fsel[2];
            4'h6:    f = r.fsel[3];
            4'h7:    f = r.fsel[4];
            4'h8:    f = r.od;
            4'h9:    f = r.pu;
            4'ha:    f = r.pd;
            4'hb:    f = r.ie;
            default: f = '0;
        endcase
        w = '0;
        w[`FLD_HI:`FLD_LO] = f;
        return w;
    endfunction

    pin_sync #(
        .W (PINS)
    ) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (padIn),
        .q     (pinSync)
    );

    pin_ctrl u_ctrl (
        .regs         (s_r.regs),
        .stopMode     (stopMode),
        .standbyDrive (standbyDrive),
        .altOut       (altOut),
        .altValid     (altValid),
        .pinIn        (pinSync),
        .pad          (padNxt),
        .altIn        (altInNxt),
        .extInt       (extIntNxt)
    );

    // Bus slave and register file; writes land before the read is formed
    always_comb begin
        pins_t wf;
        s_nxt = s_r;
        wf    = hwdata[`FLD_HI:`FLD_LO];
        if (s_r.aph.valid && s_r.aph.write) begin
            case (regIndex(s_r.aph.addr))
                4'h1:    s_nxt.regs.data    = wf;
                4'h2:    s_nxt.regs.oe      = wf;
                4'h3:    s_nxt.regs.fsel[0] = wf;
                4'h4:    s_nxt.regs.fsel[1] = wf;
                4'h5:    s_nxt.regs.fsel[2] = wf;
                4'h6:    s_nxt.regs.fsel[3] = wf;
                4'h7:    s_nxt.regs.fsel[4] = wf;
                4'h8:    s_nxt.regs.od      = wf;
                4'h9:    s_nxt.regs.pu      = wf;
                4'ha:    s_nxt.regs.pd      = wf;
                4'hb:    s_nxt.regs.ie      = wf;
                default: s_nxt.regs         = s_r.regs;
            endcase
        end
        s_nxt.aph.valid = hsel && htrans[1] && hready;
        s_nxt.aph.write = hwrite;
        s_nxt.aph.addr  = haddr[7:0];
        // Forwarded read avoids stale data after a back-to-back write
        if (hsel && htrans[1] && hready && !hwrite) begin
            s_nxt.rdata = readWord(s_nxt.regs, haddr[7:0], pinSync);
        end else begin
            s_nxt.rdata = '0;
        end
        s_nxt.ready  = 1'b1;
        s_nxt.resp   = 1'b0;
        s_nxt.pad    = padNxt;
        s_nxt.altIn  = altInNxt;
        s_nxt.extInt = extIntNxt;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.regs   <= regsReset();
            s_r.ready  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every output comes straight from the state register
    assign hreadyout = s_r.ready;
    assign hresp     = s_r.resp;
    assign hrdata    = s_r.rdata;
    assign pad       = s_r.pad;
    assign altIn     = s_r.altIn;
    assign extIntA   = s_r.extInt;

    // Checks on bus, pin steering and STOP behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    pins_t anySel;
    always_comb begin
        anySel = '0;
        for (int f = 0; f < FUNCS; f++) begin
            anySel = anySel | s_r.regs.fsel[f];
        end
    end

    sequence wrAddr(logic [7:0] ofs);
        hsel && htrans[1] && hready && hwrite && haddr[7:0] == ofs;
    endsequence

    sequence rdAddr(logic [7:0] ofs);
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == ofs;
    endsequence

    reset_debug_a: assert property ($rose(rst_n) |-> s_r.regs.fsel[`FN_DEBUG] == 4'hf)
        else $error("pins not handed to debug after reset");

    oe_write_a: assert property (wrAddr(`OFS_OE) ##1 1'b1 |=> s_r.regs.oe == $past(hwdata[`FLD_HI:`FLD_LO]))
        else $error("output enable write lost");

    oe_readback_a: assert property (rdAddr(`OFS_OE) ##0 !(s_r.aph.valid && s_r.aph.write)
                                    |=> hrdata == {25'h0, $past(s_r.regs.oe), 3'h0})
        else $error("output enable readback wrong");

    unused_zero_a: assert property (hrdata[31:7] == 25'h0 && hrdata[2:0] == 3'h0)
        else $error("unused read bits not zero");

    zero_wait_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");

    od_high_a: assert property (##1 (pad.oe & $past(s_r.regs.od) & pad.out) == 4'h0)
        else $error("open drain pin drives high");

    stop_off_a: assert property (stopMode && !standbyDrive |=> (pad.oe & ~$past(anySel)) == 4'h0)
        else $error("port output driven in stop");

    stop_keep_a: assert property (stopMode && standbyDrive
                                  |=> (pad.oe & ~$past(anySel) & ~$past(s_r.regs.od))
                                      == ($past(s_r.regs.oe) & ~$past(anySel) & ~$past(s_r.regs.od)))
        else $error("drive control ignored in stop");

    dbg_low_a: assert property (s_r.regs.fsel[`FN_DEBUG][0] |=> pad.ie[0] && pad.pu[0])
        else $error("low debug pin not input with pull-up");

    dbg_second_a: assert property (s_r.regs.fsel[`FN_DEBUG][1] |=> pad.ie[1] && pad.pd[1])
        else $error("second debug pin not input with pull-down");

    tdo_drive_a: assert property (s_r.regs.fsel[`FN_DEBUG][2] && altValid[`FN_DEBUG][2] && !s_r.regs.od[2]
                                  |=> pad.oe[2] && pad.out[2] == $past(altOut[`FN_DEBUG][2]))
        else $error("trace output not driven");

    int_pass_a: assert property (!stopMode && s_r.regs.ie[`PIN_INT] |=> extIntA == $past(pinSync[`PIN_INT]))
        else $error("interrupt not passed outside stop");

    int_stop_a: assert property (stopMode && !s_r.regs.fsel[`FN_INT][`PIN_INT] |=> !extIntA)
        else $error("unselected interrupt passed in stop");

    ie_gate_a: assert property (!anySel[0] && !s_r.regs.ie[0] |=> !altIn[0])
        else $error("disabled input reaches function");

    // Write address phase and the data phase that carries its word
    sequence wrPhase(logic [7:0] ofs);
        wrAddr(ofs) ##1 1'b1;
    endsequence

    // Register writes, read data and map holes
    data_write_a: assert property (wrPhase(`OFS_DATA)
                                   |=> s_r.regs.data == $past(hwdata[`FLD_HI:`FLD_LO]))
        else $error("data write lost");

    ie_write_a: assert property (wrPhase(`OFS_IE)
                                 |=> s_r.regs.ie == $past(hwdata[`FLD_HI:`FLD_LO]))
        else $error("input enable write lost");

    // Read data stands for its data phase only
    rdata_idle_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside data phase");

    // Holes in the map read as zero
    unmapped_read_a: assert property (rdAddr(8'h1c) |=> hrdata == 32'h0)
        else $error("unmapped offset not zero");

    // Pin steering
    dbg_top_a: assert property (s_r.regs.fsel[`FN_DEBUG][3]
                                |=> pad.ie[3] && pad.pu[3] && !pad.oe[3])
        else $error("top debug pin not input with pull-up");

    dbg_stop_in_a: assert property (stopMode && !standbyDrive && s_r.regs.fsel[`FN_DEBUG][1]
                                    |=> pad.ie[1])
        else $error("debug input lost in stop");

    int_wake_a: assert property (stopMode && s_r.regs.fsel[`FN_INT][`PIN_INT] && s_r.regs.ie[`PIN_INT]
                                 |=> extIntA == $past(pinSync[`PIN_INT]))
        else $error("selected interrupt blocked in stop");

    port_select_a: assert property (!anySel[2] && !stopMode && s_r.regs.oe[2] && !s_r.regs.od[2]
                                    |=> pad.oe[2] && pad.out[2] == $past(s_r.regs.data[2]))
        else $error("third pin not back on port");

    // Outside debug use the pulls follow their registers
    pu_follow_a: assert property (##1 ((pad.pu ^ $past(s_r.regs.pu))
                                       & ~$past(s_r.regs.fsel[`FN_DEBUG])) == 4'h0)
        else $error("pull-up does not follow register");

    pd_follow_a: assert property (##1 ((pad.pd ^ $past(s_r.regs.pd))
                                       & ~$past(s_r.regs.fsel[`FN_DEBUG])) == 4'h0)
        else $error("pull-down does not follow register");

    alt_out_a: assert property (s_r.regs.fsel[2][3] && !s_r.regs.fsel[`FN_DEBUG][3] && altValid[2][3]
                                && !stopMode && !s_r.regs.od[3] |=> pad.oe[3])
        else $error("selected function output not driven");

    stop_ie_a: assert property (stopMode && standbyDrive |=> ((pad.ie ^ $past(s_r.regs.ie))
                                & ~$past(s_r.regs.fsel[`FN_DEBUG])) == 4'h0)
        else $error("input enable ignored in stop with drive");

endmodule

`default_nettype wire

// *** test/pin_world.sv ***
/*
 * Board side of the four pins: resolves each wire from the port's pad
 * controls, an external driver and the pulls, and returns the level.
 * Assumes pad controls change only on mclk edges.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_world
    import port_pkg::*;
(
    input  wire logic  mclk,
    input  wire pad_s  pad,
    input  wire pins_t extEn,
    input  wire pins_t extVal,
    output var  pins_t padIn
);
    pins_t floatLvl = 4'h5;

    // A floating pin wanders every cycle so a stale level is never trusted
    always @(posedge mclk) begin
        floatLvl <= ~floatLvl;
    end

    // Own driver wins, then the board driver, then the pulls
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (pad.oe[i])
                padIn[i] = pad.out[i];
            else if (extEn[i])
                padIn[i] = extVal[i];
            else if (pad.pu[i])
                padIn[i] = 1'b1;
            else if (pad.pd[i])
                padIn[i] = 1'b0;
            else
                padIn[i] = floatLvl[i];
        end
    end
endmodule
`default_nettype wire

// *** test/four_bit_io_port_test.sv ***
/*
 * Self-checking bench for the four-bit port: AHB-Lite master tasks,
 * one task per scenario, pins resolved by pin_world.
 * Assumes zero-wait slave whose hreadyout feeds hready.
 */
`timescale 1ns/1ps
`default_nettype none

module four_bit_io_port_test
    import port_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        stopMode = 1'b0;
    logic        standbyDrive = 1'b0;
    fn_t         altOut = '0;
    fn_t         altValid = '0;
    pins_t       altIn;
    logic        extIntA;
    pins_t       padIn;
    pad_s        pad;
    pins_t       extEn = 4'hf;
    pins_t       extVal = 4'h0;
    int          n_fail = 0;
    int          cmp_count = 0;
    localparam logic [7:0]  ofsTab [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h28, 8'h2c,
                                            8'h30, 8'h38};
    localparam logic [31:0] rstTab [11] = '{32'h0, 32'h28, 32'h78, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h48,
                                            32'h10, 32'h58};

    always #2.5 mclk = ~mclk;
    assign hready = hreadyout;

    four_bit_io_port dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .stopMode(stopMode), .standbyDrive(standbyDrive), .altOut(altOut),
        .altValid(altValid), .altIn(altIn), .extIntA(extIntA), .padIn(padIn), .pad(pad));
    pin_world world_u (.mclk(mclk), .pad(pad), .extEn(extEn), .extVal(extVal), .padIn(padIn));

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic pinChk(input string name, input pins_t seen, input pins_t exp);
        chk(name, {28'h0, seen}, {28'h0, exp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Bounded wait for hready; a hang ends the run as a failure
    task automatic waitReady();
        int k;
        k = 0;
        @(posedge mclk);
        while (hready !== 1'b1) begin
            k++;
            if (k > 20) begin
                n_fail++;
                summarize();
            end
            @(posedge mclk);
        end
    endtask

    // One single word transfer; entered right after a rising edge
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rdv);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, ofs};
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
        rdv = hrdata;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, ofs, d, x);
    endtask

    task automatic rdChk(input string name, input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, ofs, 32'h0, x);
        chk(name, x, exp);
    endtask

    task automatic testReset();
        for (int i = 0; i < 11; i++)
            rdChk("reset value", ofsTab[i], rstTab[i]);
        pinChk("reset ie", pad.ie, 4'hb);
        pinChk("reset pull-up", pad.pu, 4'h9);
        pinChk("reset pull-down", pad.pd, 4'h2);
        pinChk("reset oe", pad.oe, 4'h0);
    endtask

    // Each register is written and read straight back, with one idle bus cycle between
    task automatic testRegs();
        for (int i = 1; i < 11; i++) begin
            wr(ofsTab[i], 32'hffff_ffff);
            rdChk("writable bits", ofsTab[i], 32'h78);
        end
        wr(8'h38, 32'h0);
        wr(8'h00, 32'hffff_ffff);
        rdChk("data latch", 8'h00, 32'h78);
        wr(8'h1c, 32'hffff_ffff);
        rdChk("unmapped", 8'h1c, 32'h0);
        for (int i = 0; i < 11; i++)
            wr(ofsTab[i], 32'h0);
    endtask

    task automatic testGpio();
        wr(8'h04, 32'h78);
        wr(8'h00, 32'h50);
        settle(3);
        pinChk("port out", pad.out, 4'ha);
        pinChk("port oe", pad.oe, 4'hf);
        wr(8'h28, 32'h78);
        settle(3);
        pinChk("open drain oe", pad.oe, 4'h5);
        wr(8'h28, 32'h0);
        wr(8'h04, 32'h40);
        settle(3);
        pinChk("oe off", pad.oe, 4'h8);
        wr(8'h04, 32'h0);
        wr(8'h2c, 32'h18);
        wr(8'h30, 32'h60);
        settle(3);
        pinChk("pull-up", pad.pu, 4'h3);
        pinChk("pull-down", pad.pd, 4'hc);
        wr(8'h2c, 32'h0);
        wr(8'h30, 32'h0);
    endtask

    task automatic testInput();
        pinChk("ie default", pad.ie, 4'h0);
        extVal <= 4'h6;
        wr(8'h38, 32'h78);
        settle(5);
        pinChk("ie on", pad.ie, 4'hf);
        pinChk("alt in", altIn, 4'h6);
        rdChk("pin read", 8'h00, 32'h30);
    endtask

    task automatic testStop();
        extVal <= 4'he;
        settle(5);
        chk("int run", {31'h0, extIntA}, 32'h1);
        stopMode <= 1'b1;
        standbyDrive <= 1'b0;
        settle(3);
        chk("int stop", {31'h0, extIntA}, 32'h0);
        pinChk("stop ie", pad.ie, 4'h0);
        wr(8'h14, 32'h40);
        settle(3);
        chk("int wake", {31'h0, extIntA}, 32'h1);
        pinChk("wake ie", pad.ie, 4'h8);
        wr(8'h14, 32'h0);
        wr(8'h04, 32'h78);
        standbyDrive <= 1'b1;
        settle(3);
        pinChk("drive ie", pad.ie, 4'hf);
        pinChk("drive oe", pad.oe, 4'hf);
        standbyDrive <= 1'b0;
        settle(3);
        pinChk("no drive oe", pad.oe, 4'h0);
        stopMode <= 1'b0;
        wr(8'h04, 32'h0);
    endtask

    // Debug roles in STOP without drive, then the third pin back to port
    task automatic testDebug();
        wr(8'h38, 32'h0);
        altOut[0] <= 4'hf;
        altValid[0] <= 4'hf;
        wr(8'h08, 32'h78);
        stopMode <= 1'b1;
        settle(3);
        pinChk("debug oe", pad.oe, 4'h5);
        pinChk("debug out", pad.out & 4'h5, 4'h5);
        pinChk("debug ie", pad.ie, 4'hb);
        pinChk("debug pulls", pad.pu, 4'h9);
        altValid[0] <= 4'h0;
        settle(3);
        pinChk("debug idle", pad.oe, 4'h0);
        wr(8'h08, 32'h58);
        wr(8'h04, 32'h78);
        altValid[0] <= 4'hf;
        settle(3);
        pinChk("third pin gated", pad.oe, 4'h1);
        stopMode <= 1'b0;
        settle(3);
        pinChk("third pin port", pad.oe, 4'h5);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h0);
        altValid[0] <= 4'h0;
    endtask

    task automatic testAlt();
        altOut[2] <= 4'h8;
        altValid[2] <= 4'h8;
        wr(8'h10, 32'h40);
        settle(3);
        pinChk("timer oe", pad.oe, 4'h8);
        pinChk("timer out", pad.out & 4'h8, 4'h8);
        altValid[2] <= 4'h0;
        settle(3);
        pinChk("timer idle", pad.oe, 4'h0);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        settle(2);
        testReset();
        testRegs();
        testGpio();
        testInput();
        testStop();
        testDebug();
        testAlt();
        summarize();
    end
endmodule
`default_nettype wire
